// ### rtl/sopd_rx.sv
// Receive end: deserialises the link into parallel pixel words
//
// Overview of operation
// - Seven slots per period, evenly spaced strobes
// - Lock within ten milliseconds; no output before
// - Sleep low forces all outputs low
// - Sleep reaches low outputs within one microsecond
// - Pixel word strobed on pixel clock falling edge
// - Four pairs give twenty-eight outputs
// - Three pairs give twenty-one outputs
// - Pixel clock follows link clock period only while panel_ready stays high
// - Signal to output mapping is system choice
`timescale 1ns/1ns
module sopd_rx
    import sopd_pkg::*;
#(
    parameter int PAIRS          = SOPD_PAIRS_24,
    parameter int WORD_W         = SOPD_SLOTS * PAIRS,
    parameter int LOCK_LIMIT_CYC = SOPD_LOCK_MAX_CYC
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    sopd_link_if.rx                link,
    input  wire logic              sleep_n,
    input  wire logic              panel_ready,
    output logic [WORD_W-1:0]      parallel_pixel_out,
    output logic                   pixel_clock_out,
    output logic                   link_locked,
    output logic                   rx_overrun
);

    localparam int LT_W = $clog2(LOCK_LIMIT_CYC + 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                   clk_s1;
        logic                   clk_s2;
        logic                   clk_s3;
        logic [PAIRS-1:0]       dat_s1;
        logic [PAIRS-1:0]       dat_s2;
        logic                   slp_s1;
        logic                   slp_s2;
        sopd_cnt_t              cnt;
        sopd_cnt_t              period;
        logic [2:0]             match;
        logic                   locked;
        logic [LT_W-1:0]        acq;
        logic [3:0]             slot;
        logic [WORD_W-1:0]      shreg;
        logic [1:0][WORD_W-1:0] mem;
        logic                   wr_ptr;
        logic                   rd_ptr;
        logic [1:0]             fill;
        sopd_pix_t              pst;
        logic [1:0]             pcnt;
        logic [WORD_W-1:0]      pix;
        logic                   pclk;
        logic                   overrun;
    } sopd_rx_st_t;

    localparam sopd_rx_st_t RX_RST = '{pst: SOPD_PIX_IDLE, default: '0};

    sopd_rx_st_t r_ff;
    sopd_rx_st_t nxt_r;

    // ------------------------------------------------------------------
    // Strobe k falls due at (2k+1)/14 of the measured period
    // ------------------------------------------------------------------
    function automatic logic strobe_due(sopd_cnt_t cnt, logic [3:0] slot, sopd_cnt_t period);
        logic [15:0] lhs;
        logic [15:0] rhs;
        lhs = (16'(cnt) + 16'h0001) * 16'(SOPD_STROBE_DEN);
        rhs = (16'(slot) * 16'h0002 + 16'h0001) * 16'(period);
        return lhs >= rhs;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic      rise;
        logic      push;
        logic      pop;
        logic      buf_ready;
        sopd_cnt_t cnt_plus;
        nxt_r     = r_ff;
        push      = 1'b0;
        pop       = 1'b0;
        buf_ready = (r_ff.fill != 2'h2);
        cnt_plus  = r_ff.cnt + SOPD_CNT_ONE;
        rise      = r_ff.clk_s2 & ~r_ff.clk_s3;

        // Pins cross in through two flops each
        nxt_r.clk_s1 = link.link_clock_pair;
        nxt_r.clk_s2 = r_ff.clk_s1;
        nxt_r.clk_s3 = r_ff.clk_s2;
        nxt_r.dat_s1 = link.serial_data_pair;
        nxt_r.dat_s2 = r_ff.dat_s1;
        nxt_r.slp_s1 = sleep_n;
        nxt_r.slp_s2 = r_ff.slp_s1;

        // Period tracking and slot sampling
        if (rise) begin
            nxt_r.cnt    = '0;
            nxt_r.slot   = '0;
            nxt_r.shreg  = '0;
            nxt_r.period = cnt_plus;
            if (cnt_plus == r_ff.period) begin
                if (r_ff.match != SOPD_LOCK_MATCH) begin
                    nxt_r.match = r_ff.match + 3'h1;
                end
            end else begin
                nxt_r.match = '0;
            end
            nxt_r.locked = (nxt_r.match == SOPD_LOCK_MATCH);
            // Only complete words from a locked link are passed on
            if (r_ff.locked && r_ff.slot == SOPD_SLOT_END) begin
                if (buf_ready) begin
                    push = 1'b1;
                end else begin
                    nxt_r.overrun = 1'b1;
                end
            end
        end else begin
            if (r_ff.cnt != SOPD_CNT_MAX) begin
                nxt_r.cnt = cnt_plus;
            end else begin
                // Link clock stopped: forget the period
                nxt_r.period = '0;
                nxt_r.match  = '0;
                nxt_r.locked = 1'b0;
            end
            if (r_ff.slot != SOPD_SLOT_END && r_ff.period != '0
                && strobe_due(r_ff.cnt, r_ff.slot, r_ff.period)) begin
                for (int p = 0; p < PAIRS; p++) begin
                    nxt_r.shreg[sopd_bit_idx(p, int'(r_ff.slot))] = r_ff.dat_s2[p];
                end
                nxt_r.slot = r_ff.slot + 4'h1;
            end
        end

        // Acquisition restarts if lock takes longer than allowed
        if (r_ff.locked) begin
            nxt_r.acq = '0;
        end else if (r_ff.acq == LT_W'(LOCK_LIMIT_CYC - 1)) begin
            nxt_r.acq    = '0;
            nxt_r.period = '0;
            nxt_r.match  = '0;
        end else begin
            nxt_r.acq = r_ff.acq + LT_W'(1);
        end

        // Pixel output stage: rise with data, fall as strobe
        unique case (r_ff.pst)
            SOPD_PIX_IDLE: begin
                if (r_ff.fill != '0 && panel_ready) begin
                    pop           = 1'b1;
                    nxt_r.pix     = r_ff.mem[r_ff.rd_ptr];
                    nxt_r.pclk    = 1'b1;
                    nxt_r.pcnt    = '0;
                    nxt_r.pst     = SOPD_PIX_HIGH;
                end
            end
            SOPD_PIX_HIGH: begin
                nxt_r.pcnt = r_ff.pcnt + 2'h1;
                if (r_ff.pcnt == 2'(SOPD_PIX_HI_CYC - 1)) begin
                    nxt_r.pclk = 1'b0;
                    nxt_r.pcnt = '0;
                    nxt_r.pst  = SOPD_PIX_LOW;
                end
            end
            SOPD_PIX_LOW: begin
                nxt_r.pcnt = r_ff.pcnt + 2'h1;
                if (r_ff.pcnt == 2'(SOPD_PIX_LO_CYC - 1)) begin
                    nxt_r.pcnt = '0;
                    nxt_r.pst  = SOPD_PIX_IDLE;
                end
            end
            default: begin
                nxt_r.pst  = SOPD_PIX_IDLE;
                nxt_r.pclk = 1'b0;
            end
        endcase

        // Two-entry buffer between link and panel
        if (push) begin
            nxt_r.mem[r_ff.wr_ptr] = r_ff.shreg;
            nxt_r.wr_ptr           = ~r_ff.wr_ptr;
        end
        if (pop) begin
            nxt_r.rd_ptr = ~r_ff.rd_ptr;
        end
        unique case ({push, pop})
            2'b10:   nxt_r.fill = r_ff.fill + 2'h1;
            2'b01:   nxt_r.fill = r_ff.fill - 2'h1;
            default: nxt_r.fill = r_ff.fill;
        endcase

        // Sleep clears everything but the synchronisers; three clocks from pin
        if (!r_ff.slp_s2) begin
            nxt_r        = RX_RST;
            nxt_r.clk_s1 = link.link_clock_pair;
            nxt_r.clk_s2 = r_ff.clk_s1;
            nxt_r.clk_s3 = r_ff.clk_s2;
            nxt_r.dat_s1 = link.serial_data_pair;
            nxt_r.dat_s2 = r_ff.dat_s1;
            nxt_r.slp_s1 = sleep_n;
            nxt_r.slp_s2 = r_ff.slp_s1;
        end
    end

    // ------------------------------------------------------------------
    // Register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_ff <= RX_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flops; width set by PAIRS
    // ------------------------------------------------------------------
    assign parallel_pixel_out = r_ff.pix;
    assign pixel_clock_out    = r_ff.pclk;
    assign link_locked        = r_ff.locked;
    assign rx_overrun         = r_ff.overrun;

endmodule

// ### pkg/sopd_pkg.sv
// Shared constants, types and bit mapping of the seven-to-one pixel link
package sopd_pkg;

    // ------------------------------------------------------------------
    // Link framing
    // ------------------------------------------------------------------
    localparam int SOPD_SLOTS         = 7;     // Bit slots per link clock period
    localparam int SOPD_PAIRS_24      = 4;     // 24-bit colour variant
    localparam int SOPD_PAIRS_18      = 3;     // 18-bit colour variant
    localparam int SOPD_WORD_24       = 28;
    localparam int SOPD_WORD_18       = 21;
    localparam int SOPD_COLOR_BITS_24 = 8;
    localparam int SOPD_COLOR_BITS_18 = 6;
    localparam int SOPD_STROBE_DEN    = 2 * SOPD_SLOTS;  // Strobe k at (2k+1)/14 of period

    // Suggested control positions above the three colour fields
    localparam int SOPD_LINE_SYNC_OFS   = 0;
    localparam int SOPD_FRAME_SYNC_OFS  = 1;
    localparam int SOPD_PIXEL_VALID_OFS = 2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SOPD_CLK_NS        = 40;
    localparam int SOPD_SLOT_CYC      = 4;     // Transmit divider, clocks per slot
    localparam int SOPD_LINK_HI_SLOTS = 4;     // Link clock high for slots 0..3
    localparam int SOPD_LOCK_TIME_MS  = 10;
    localparam int SOPD_LOCK_MAX_CYC  = SOPD_LOCK_TIME_MS * 1000000 / SOPD_CLK_NS;
    localparam int SOPD_SLEEP_TIME_NS = 1000;
    localparam int SOPD_SLEEP_MAX_CYC = SOPD_SLEEP_TIME_NS / SOPD_CLK_NS;
    localparam int SOPD_PIX_HI_CYC    = 2;
    localparam int SOPD_PIX_LO_CYC    = 2;

    // ------------------------------------------------------------------
    // Receive counters and lock
    // ------------------------------------------------------------------
    localparam int SOPD_CNT_W = 8;
    typedef logic [SOPD_CNT_W-1:0] sopd_cnt_t;
    localparam sopd_cnt_t   SOPD_CNT_MAX    = 8'hFF;
    localparam sopd_cnt_t   SOPD_CNT_ONE    = 8'h01;
    localparam logic [2:0]  SOPD_LOCK_MATCH = 3'h4;  // Successive period matches needed for lock
    localparam logic [3:0]  SOPD_SLOT_END   = 4'h7;

    typedef enum logic [2:0] {
        SOPD_PIX_IDLE = 3'h1,
        SOPD_PIX_HIGH = 3'h2,
        SOPD_PIX_LOW  = 3'h4
    } sopd_pix_t;

    // ------------------------------------------------------------------
    // Word bit carried by a given pair and slot
    // ------------------------------------------------------------------
    function automatic int sopd_bit_idx(int pair, int slot);
        return pair * SOPD_SLOTS + slot;
    endfunction

endpackage

// ### pkg/sopd_link_if.sv
// Serial link between the transmit end and the receive end
`timescale 1ns/1ns
interface sopd_link_if #(
    parameter int PAIRS = 4
) ();
    logic             link_clock_pair;
    logic [PAIRS-1:0] serial_data_pair;

    modport tx (
        output link_clock_pair,
        output serial_data_pair
    );

    modport rx (
        input  link_clock_pair,
        input  serial_data_pair
    );
endinterface

// ### rtl/sopd_tx.sv
// Transmit end: serialises parallel words onto the link
`timescale 1ns/1ns
module sopd_tx
    import sopd_pkg::*;
#(
    parameter int PAIRS  = SOPD_PAIRS_24,
    parameter int WORD_W = SOPD_SLOTS * PAIRS
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    sopd_link_if.tx                link,
    input  wire logic [WORD_W-1:0] pixel_word,
    input  wire logic              word_valid,
    output logic                   word_ready
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]        cyc;
        logic [2:0]        slot;
        logic [WORD_W-1:0] word;
        logic              lclk;
        logic [PAIRS-1:0]  dat;
    } sopd_tx_st_t;

    localparam sopd_tx_st_t TX_RST = '{slot: 3'(SOPD_SLOTS - 1), default: '0};

    sopd_tx_st_t r_ff;
    sopd_tx_st_t nxt_r;
    logic        last_cyc;
    logic        last_slot;

    assign last_cyc   = (r_ff.cyc == 2'(SOPD_SLOT_CYC - 1));
    assign last_slot  = (r_ff.slot == 3'(SOPD_SLOTS - 1));
    // Word is taken only at the period boundary
    assign word_ready = last_cyc & last_slot & ~sys_rst;

    // ------------------------------------------------------------------
    // Slot sequencer
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0]        ns;
        logic [WORD_W-1:0] nw;
        nxt_r = r_ff;
        ns    = r_ff.slot;
        nw    = r_ff.word;
        nxt_r.cyc = r_ff.cyc + 2'h1;
        if (last_cyc) begin
            nxt_r.cyc = '0;
            ns        = last_slot ? '0 : r_ff.slot + 3'h1;
            // Idle periods send all zeros, so the valid line stays low
            if (last_slot) begin
                nw = word_valid ? pixel_word : '0;
            end
            nxt_r.slot = ns;
            nxt_r.word = nw;
            nxt_r.lclk = (ns < 3'(SOPD_LINK_HI_SLOTS));
            for (int p = 0; p < PAIRS; p++) begin
                nxt_r.dat[p] = nw[sopd_bit_idx(p, int'(ns))];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_ff <= TX_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign link.link_clock_pair  = r_ff.lclk;
    assign link.serial_data_pair = r_ff.dat;

endmodule

// ### dv/sopd_link_monitor.sv
// Framing checker watching the serial link between the two ends
`timescale 1ns/1ns
module sopd_link_monitor
    import sopd_pkg::*;
#(
    parameter int PAIRS = 4
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             link_clock_pair,
    input  wire logic [PAIRS-1:0] serial_data_pair
);
    // ------------------------------------------------------------------
    // Clocks since the last link clock rise
    // ------------------------------------------------------------------
    logic       lclk_d_ff;
    logic [7:0] since_rise_ff;
    logic       rise;

    assign rise = link_clock_pair && !lclk_d_ff;

    always_ff @(posedge clk) begin
        lclk_d_ff     <= sys_rst ? 1'h0 : link_clock_pair;
        since_rise_ff <= (sys_rst || rise) ? 8'h01 : since_rise_ff + 8'h01;
    end

    // ------------------------------------------------------------------
    // Link framing
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_reset_link_quiet: assert property ($fell(sys_rst) |->
        !link_clock_pair && serial_data_pair == '0) else $error("link not quiet after reset");
    a_first_rise_soon: assert property ($fell(sys_rst) |-> ##[1:6] link_clock_pair)
        else $error("no link clock after reset");
    a_clock_high_span: assert property (rise |->
        link_clock_pair[*8] ##1 link_clock_pair[*8] ##1 !link_clock_pair)
        else $error("link clock high span wrong");
    a_clock_low_span: assert property ($fell(link_clock_pair) |->
        !link_clock_pair[*8] ##1 !link_clock_pair[*4] ##1 link_clock_pair)
        else $error("link clock low span wrong");
    a_link_period: assert property (rise |-> ##28 rise)
        else $error("link period not 28 clocks");
    a_slot_hold: assert property ($changed(serial_data_pair) |=>
        $stable(serial_data_pair)[*3]) else $error("slot shorter than 4 clocks");
    a_slot_edge_only: assert property ($changed(serial_data_pair) && !rise |->
        since_rise_ff[1:0] == 2'h0) else $error("data changed off a slot boundary");
    a_fall_point: assert property ($fell(link_clock_pair) |-> since_rise_ff == 8'h10)
        else $error("link clock fell off slot 4");
endmodule

// ### dv/seven_to_one_pixel_deserializer_tb_top.sv
// Bench joining the transmit and receive ends over one four-pair link and one three-pair link
`timescale 1ns/1ns
module seven_to_one_pixel_deserializer_tb_top
    import sopd_pkg::*;
;
    localparam int W = SOPD_WORD_24;
    logic         clk         = 1'h0;
    logic         sys_rst     = 1'h1;
    logic         sleep_n     = 1'h1;
    logic         panel_ready = 1'h1;
    logic         word_valid  = 1'h0;
    logic [W-1:0] pixel_word  = '0;
    logic         word_ready, pixel_clock_out, link_locked, rx_overrun;
    logic [W-1:0] parallel_pixel_out;
    logic [W-1:0] src_q[$], sent_q[$], recv_q[$];
    int           fail_count  = 0;
    int           check_count = 0;
    int           cyc         = 0;
    localparam int             W18          = SOPD_WORD_18;
    localparam logic [W18-1:0] NARROW_WORD  = 21'h15A3C6;
    logic [W18-1:0]            narrow_word  = NARROW_WORD;
    logic                      narrow_valid = 1'h1;
    logic [W18-1:0]            pix18;
    logic                      lock18;

    always #20 clk = ~clk;

    sopd_link_if #(.PAIRS(SOPD_PAIRS_24)) link_if ();
    sopd_tx #(.PAIRS(SOPD_PAIRS_24)) sopd_tx_i (.clk(clk), .sys_rst(sys_rst), .link(link_if.tx),
        .pixel_word(pixel_word), .word_valid(word_valid), .word_ready(word_ready));
    sopd_rx #(.PAIRS(SOPD_PAIRS_24), .LOCK_LIMIT_CYC(2000)) sopd_rx_i (.clk(clk),
        .sys_rst(sys_rst), .link(link_if.rx), .sleep_n(sleep_n), .panel_ready(panel_ready),
        .parallel_pixel_out(parallel_pixel_out), .pixel_clock_out(pixel_clock_out),
        .link_locked(link_locked), .rx_overrun(rx_overrun));
    sopd_link_monitor #(.PAIRS(SOPD_PAIRS_24)) sopd_link_monitor_i (.clk(clk),
        .sys_rst(sys_rst), .link_clock_pair(link_if.link_clock_pair),
        .serial_data_pair(link_if.serial_data_pair));

    // Three-pair variant on its own link, fed one fixed word
    sopd_link_if #(.PAIRS(SOPD_PAIRS_18)) link18_if ();
    sopd_tx #(.PAIRS(SOPD_PAIRS_18)) sopd_tx18_i (.clk(clk), .sys_rst(sys_rst),
        .link(link18_if.tx), .pixel_word(narrow_word), .word_valid(narrow_valid),
        .word_ready());
    sopd_rx #(.PAIRS(SOPD_PAIRS_18), .LOCK_LIMIT_CYC(2000)) sopd_rx18_i (.clk(clk),
        .sys_rst(sys_rst), .link(link18_if.rx), .sleep_n(sleep_n), .panel_ready(panel_ready),
        .parallel_pixel_out(pix18), .pixel_clock_out(), .link_locked(lock18),
        .rx_overrun());

    // ------------------------------------------------------------------
    // Feeder and panel capture
    // ------------------------------------------------------------------
    // An idle feeder still sends zero words, so they are recorded too
    always @(posedge clk) begin
        if (!sys_rst && word_ready === 1'h1) begin
            sent_q.push_back(word_valid ? pixel_word : '0);
            #1;
            word_valid = (src_q.size() > 0);
            pixel_word = word_valid ? src_q.pop_front() : '0;
        end
    end

    always @(negedge pixel_clock_out) recv_q.push_back(parallel_pixel_out);

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_lock();
        int n;
        n = 0;
        while (link_locked !== 1'h1 && n < 2000) begin
            tick(1);
            n++;
        end
        check("link_locked", W'(link_locked), W'(1'h1));
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Mapping patterns plus a short panel stall that the buffer absorbs
    task automatic t_stream();
        @(posedge clk iff word_ready === 1'h1);
        @(posedge clk iff word_ready === 1'h1);
        #2;
        sent_q = sent_q[$-1:$];
        recv_q.delete();
        src_q = '{28'h0000001, 28'h8000000, 28'hFFFFFFF, 28'hA5A5A5A, 28'h5A5A5A5, 28'h1234567};
        tick(40);
        panel_ready = 1'h0;
        tick(40);
        panel_ready = 1'h1;
        tick(240);
        check("strobe_count", W'(recv_q.size() inside {[10:12]}), W'(1'h1));
        for (int i = 0; i < 9; i++) begin
            check("pixel_word", recv_q[i], sent_q[i]);
        end
        check("no_overrun", W'(rx_overrun), '0);
    endtask

    // Long stall of four link periods: two words held, the third and fourth are lost
    task automatic t_overrun();
        panel_ready = 1'h0;
        tick(112);
        check("overrun", W'(rx_overrun), W'(1'h1));
        recv_q.delete();
        panel_ready = 1'h1;
        tick(20);
        check("held_words", W'(recv_q.size() inside {[2:3]}), W'(1'h1));
    endtask

    // Sleep while a non-zero word is shown, so a slow clear would be seen
    task automatic t_sleep();
        src_q.push_back(28'hFFFFFFF);
        @(posedge clk iff parallel_pixel_out === 28'hFFFFFFF);
        #1;
        sleep_n = 1'h0;
        tick(3);
        check("sleep_fast", parallel_pixel_out, '0);
        for (int i = 0; i < 40; i++) begin
            tick(1);
            check("sleep_word", parallel_pixel_out, '0);
            check("sleep_clock", W'(pixel_clock_out), '0);
        end
        check("sleep_unlock", W'({link_locked, rx_overrun}), '0);
        sleep_n = 1'h1;
        wait_lock();
    endtask

    // Three-pair end must rebuild the fixed word bit for bit
    task automatic t_narrow();
        check("narrow_lock", W'(lock18), W'(1'h1));
        check("narrow_word", W'(pix18), W'(NARROW_WORD));
    endtask

    initial begin
        tick(2);
        check("reset_word", parallel_pixel_out, '0);
        sys_rst = 1'h0;
        recv_q.delete();
        wait_lock();
        check("early_strobes", W'(recv_q.size()), '0);
        t_stream();
        t_overrun();
        t_sleep();
        t_stream();
        t_narrow();
        wrap_up();
    end
endmodule
